// file: rspc_pkg.sv
`default_nettype none
package rspc_pkg;
   localparam int TW = 16;
   localparam logic [2:0] MODE_COMFORT = 3'h0;
   localparam logic [2:0] MODE_STANDBY = 3'h1;
   localparam logic [2:0] MODE_NIGHT = 3'h2;
   localparam logic [2:0] MODE_PROTECT = 3'h3;
   localparam logic [1:0] WHEEL_OFFSET = 2'h0;
   localparam logic [1:0] WHEEL_BASIC = 2'h1;
   localparam logic [1:0] WHEEL_OFF_OBJ = 2'h2;
   localparam logic [1:0] WHEEL_OFF = 2'h3;
   localparam logic [1:0] MAX_1K = 2'h0;
   localparam logic [1:0] MAX_2K = 2'h1;
   localparam logic [1:0] MAX_3K = 2'h2;
   localparam logic signed [TW-1:0] K1 = 16'sh0064;
   localparam logic signed [TW-1:0] K2 = 16'sh00C8;
   localparam logic signed [TW-1:0] K3 = 16'sh012C;
   localparam logic signed [4:0] NOTCH_MAX = 5'sh06;
   localparam logic [1:0] PAIR_NONE = 2'h0;
   localparam logic [1:0] PAIR_BLINDS = 2'h1;
   localparam logic [1:0] PAIR_DIMMER = 2'h2;
endpackage
`default_nettype wire

// file: rspc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Heat comfort: basic plus offset
// - Heat standby: minus standby reduction
// - Heat night: minus night reduction
// - Heat protection: frost setpoint
// - Cool comfort: basic, offset, dead zone
// - Cool standby: add standby increase
// - Cool night: add night increase
// - Cool protection: heat protection setpoint
// - Report new offset value on change
// - Clamp offset to configured maximum
// - Wheel centre gives zero offset
// - Wheel end stop gives maximum
// - Notch step one sixth/third/half kelvin
// - Manual offset accepted only when allowed
// - Manual offset replaces, relative to basic
// - Three inputs, enabled by configuration
// - Third input binary or sensor
// - Paired keys share two objects, three in dimmer pairing
// - Window protection, presence comfort, else preselect
module rspc_top
   import rspc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cooling,
   input wire logic [2:0] i_preselect_mode,
   input wire logic i_presence,
   input wire logic i_window_open,
   input wire logic signed [rspc_pkg::TW-1:0] i_basic_setpoint,
   input wire logic signed [rspc_pkg::TW-1:0] i_standby_reduction,
   input wire logic signed [rspc_pkg::TW-1:0] i_night_reduction,
   input wire logic signed [rspc_pkg::TW-1:0] i_frost_setpoint,
   input wire logic signed [rspc_pkg::TW-1:0] i_dead_zone,
   input wire logic signed [rspc_pkg::TW-1:0] i_standby_increase,
   input wire logic signed [rspc_pkg::TW-1:0] i_night_increase,
   input wire logic signed [rspc_pkg::TW-1:0] i_heat_protect_setpoint,
   input wire logic [1:0] i_wheel_function,
   input wire logic [1:0] i_max_offset_sel,
   input wire logic signed [4:0] i_wheel_notch,
   input wire logic i_manual_offset_valid,
   input wire logic signed [rspc_pkg::TW-1:0] i_manual_offset,
   input wire logic i_ext_enable,
   input wire logic i_ext_c_is_sensor,
   input wire logic [1:0] i_pair_function,
   input wire logic i_ext_input_a,
   input wire logic i_ext_input_b,
   input wire logic i_ext_input_c,
   output logic signed [rspc_pkg::TW-1:0] o_current_setpoint,
   output logic [2:0] o_current_mode,
   output logic signed [rspc_pkg::TW-1:0] o_offset_report,
   output logic o_offset_report_valid,
   output logic o_obj_a_switch,
   output logic o_obj_a_aux,
   output logic o_obj_b_switch,
   output logic o_obj_shared,
   output logic o_obj_c_switch,
   output logic o_ext_c_analog_sel
);
   import rspc_pkg::*;

   function automatic logic signed [TW-1:0] clamp_off(input logic signed [TW+1:0] v,
                                                    input logic signed [TW-1:0] lim);
      logic signed [TW+1:0] l;
      l = {{2{lim[TW-1]}}, lim};
      if (v > l)
         clamp_off = lim;
      else if (v < -l)
         clamp_off = -lim;
      else
         clamp_off = v[TW-1:0];
   endfunction

   function automatic logic signed [TW+1:0] wid(input logic signed [TW-1:0] v);
      wid = {{2{v[TW-1]}}, v};
   endfunction

   logic [1:0] sync_a;
   logic [1:0] sync_b;
   logic [1:0] sync_c;
   logic signed [4:0] notch_meta;
   logic signed [4:0] notch_sync;
   logic signed [4:0] notch_check;
   logic signed [4:0] notch;
   logic signed [TW-1:0] max_off;
   logic signed [TW-1:0] step;
   logic signed [TW+1:0] wheel_raw;
   logic signed [TW-1:0] wheel_off;
   logic signed [TW-1:0] manual_off;
   logic signed [TW-1:0] offset;
   logic signed [TW-1:0] offset_prev;
   logic signed [TW-1:0] eff_offset;
   logic manual_ok;
   logic signed [TW+1:0] next_setpoint;
   logic [2:0] next_mode;
   logic a;
   logic b;
   logic c;

   // Pins are asynchronous to the clock, so each takes two flops first
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync_a <= 2'h0;
         sync_b <= 2'h0;
         sync_c <= 2'h0;
      end
      else
      begin
         sync_a <= {sync_a[0], i_ext_input_a};
         sync_b <= {sync_b[0], i_ext_input_b};
         sync_c <= {sync_c[0], i_ext_input_c};
      end
   end

   // The knob sits outside the clock domain: two flops, then a position is taken only
   // when two settled samples agree, so a word caught mid-change never reaches the sum
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         notch_meta <= 5'sh00;
         notch_sync <= 5'sh00;
         notch_check <= 5'sh00;
      end
      else
      begin
         notch_meta <= i_wheel_notch;
         notch_sync <= notch_meta;
         notch_check <= notch_sync;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         notch <= 5'sh00;
      else if (notch_sync == notch_check)
         notch <= notch_check;
   end

   always_comb
   begin
      case (i_max_offset_sel)
         MAX_1K:
         begin
            max_off = K1;
            step = TW'(K1 / 6);
         end
         MAX_2K:
         begin
            max_off = K2;
            step = TW'(K1 / 3);
         end
         default:
         begin
            max_off = K3;
            step = TW'(K1 / 2);
         end
      endcase
   end

   // Six notches each side; full notch count times step hits the maximum
   // only approximately for 1 K and 2 K, so the end stop is forced exactly
   always_comb
   begin
      wheel_raw = wid(step) * $signed({{(TW-3){notch[4]}}, notch});
      if (notch >= NOTCH_MAX)
         wheel_off = max_off;
      else if (notch <= -NOTCH_MAX)
         wheel_off = -max_off;
      else
         wheel_off = clamp_off(wheel_raw, max_off);
   end

   assign manual_ok = (i_wheel_function == WHEEL_BASIC) || (i_wheel_function == WHEEL_OFF_OBJ);

   // Received offset replaces the old one rather than adding to it
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         manual_off <= 16'sh0000;
      else if (i_manual_offset_valid && manual_ok)
         manual_off <= clamp_off(wid(i_manual_offset), max_off);
   end

   always_comb
   begin
      if (i_wheel_function == WHEEL_OFFSET)
         eff_offset = wheel_off;
      else if (manual_ok)
         eff_offset = clamp_off(wid(manual_off), max_off);
      else
         eff_offset = 16'sh0000;
   end

   always_comb
   begin
      if (i_window_open)
         next_mode = MODE_PROTECT;
      else if (i_presence)
         next_mode = MODE_COMFORT;
      else if (i_preselect_mode > MODE_PROTECT)
         next_mode = MODE_COMFORT;
      else
         next_mode = i_preselect_mode;
   end

   // Two guard bits keep the widest sum from wrapping
   always_comb
   begin
      if (!i_cooling)
      begin
         case (next_mode)
            MODE_COMFORT: next_setpoint = wid(i_basic_setpoint) + wid(offset);
            MODE_STANDBY: next_setpoint = wid(i_basic_setpoint) + wid(offset) - wid(i_standby_reduction);
            MODE_NIGHT: next_setpoint = wid(i_basic_setpoint) + wid(offset) - wid(i_night_reduction);
            default: next_setpoint = wid(i_frost_setpoint);
         endcase
      end
      else
      begin
         case (next_mode)
            MODE_COMFORT: next_setpoint = wid(i_basic_setpoint) + wid(offset) + wid(i_dead_zone);
            MODE_STANDBY:
               next_setpoint = wid(i_basic_setpoint) + wid(offset) + wid(i_dead_zone)
                               + wid(i_standby_increase);
            MODE_NIGHT:
               next_setpoint = wid(i_basic_setpoint) + wid(offset) + wid(i_dead_zone)
                               + wid(i_night_increase);
            default: next_setpoint = wid(i_heat_protect_setpoint);
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         offset <= 16'sh0000;
      else
         offset <= eff_offset;
   end

   // Saturate rather than wrap on the output word
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_current_setpoint <= 16'sh0000;
         o_current_mode <= MODE_COMFORT;
      end
      else
      begin
         o_current_setpoint <= clamp_off(next_setpoint, 16'sh7FFF);
         o_current_mode <= next_mode;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         offset_prev <= 16'sh0000;
         o_offset_report <= 16'sh0000;
         o_offset_report_valid <= 1'b0;
      end
      else
      begin
         offset_prev <= offset;
         o_offset_report_valid <= (offset != offset_prev);
         if (offset != offset_prev)
            o_offset_report <= offset;
      end
   end

   assign a = sync_a[1] & i_ext_enable;
   assign b = sync_b[1] & i_ext_enable;
   assign c = sync_c[1] & i_ext_enable & ~i_ext_c_is_sensor;

   // Paired keys: a and b drive switch, shared and, for dimmer, aux objects; a pressed masks b on the shared object, both pressed clear the switch
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_obj_a_switch <= 1'b0;
         o_obj_a_aux <= 1'b0;
         o_obj_b_switch <= 1'b0;
         o_obj_shared <= 1'b0;
         o_obj_c_switch <= 1'b0;
         o_ext_c_analog_sel <= 1'b0;
      end
      else
      begin
         o_obj_c_switch <= c;
         o_ext_c_analog_sel <= i_ext_enable & i_ext_c_is_sensor;
         if (i_pair_function == PAIR_NONE)
         begin
            o_obj_a_switch <= a;
            o_obj_a_aux <= 1'b0;
            o_obj_b_switch <= b;
            o_obj_shared <= 1'b0;
         end
         else
         begin
            o_obj_a_switch <= a ^ b;
            o_obj_a_aux <= (a | b) & (i_pair_function == PAIR_DIMMER);
            o_obj_b_switch <= 1'b0;
            o_obj_shared <= b & ~a;
         end
      end
   end
endmodule
`default_nettype wire

// file: rspc_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
module rspc_bus_node
   import rspc_pkg::*;
(
   input wire logic i_clk,
   output logic o_valid,
   output logic signed [rspc_pkg::TW-1:0] o_value
);
   initial o_valid = 1'b0;
   initial o_value = '0;
   // Signed kelvin offset sent as one telegram, then the value line is scrambled
   task send(input logic signed [TW-1:0] v);
      @(negedge i_clk);
      o_valid = 1'b1;
      o_value = v;
      @(negedge i_clk);
      o_valid = 1'b0;
      o_value = ~v;
   endtask
endmodule
`default_nettype wire

// file: rspc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rspc_chk
   import rspc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cooling,
   input wire logic i_presence,
   input wire logic i_window_open,
   input wire logic [1:0] i_wheel_function,
   input wire logic [1:0] i_max_offset_sel,
   input wire logic signed [4:0] i_wheel_notch,
   input wire logic signed [rspc_pkg::TW-1:0] i_basic_setpoint,
   input wire logic signed [rspc_pkg::TW-1:0] i_frost_setpoint,
   input wire logic signed [rspc_pkg::TW-1:0] i_dead_zone,
   input wire logic signed [rspc_pkg::TW-1:0] i_heat_protect_setpoint,
   input wire logic signed [rspc_pkg::TW-1:0] o_current_setpoint,
   input wire logic signed [rspc_pkg::TW-1:0] o_offset_report,
   input wire logic [2:0] o_current_mode,
   input wire logic o_offset_report_valid
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   window_protect_a: assert property (i_window_open |=> o_current_mode == MODE_PROTECT)
      else $error("window open did not select protection");
   presence_comfort_a: assert property (!i_window_open && i_presence |=> o_current_mode == MODE_COMFORT)
      else $error("presence did not select comfort");
   heat_comfort_a: assert property ((!i_cooling && !i_window_open && i_presence && $stable(i_basic_setpoint)
      && $stable(o_offset_report))[*4] |-> o_current_setpoint == i_basic_setpoint + o_offset_report)
      else $error("heating comfort setpoint wrong");
   cool_comfort_a: assert property ((i_cooling && !i_window_open && i_presence && $stable(i_basic_setpoint)
      && $stable(i_dead_zone) && $stable(o_offset_report))[*4]
      |-> o_current_setpoint == i_basic_setpoint + o_offset_report + i_dead_zone)
      else $error("cooling comfort setpoint wrong");
   frost_setpoint_a: assert property ((!i_cooling && i_window_open && $stable(i_frost_setpoint))[*4]
      |-> o_current_setpoint == i_frost_setpoint)
      else $error("frost setpoint not used");
   heat_protect_a: assert property ((i_cooling && i_window_open && $stable(i_heat_protect_setpoint))[*4]
      |-> o_current_setpoint == i_heat_protect_setpoint)
      else $error("heat protection setpoint not used");
   manual_refused_a: assert property ((i_wheel_function == WHEEL_OFF)[*5] |-> $stable(o_offset_report))
      else $error("offset moved while manual object disabled");
   end_stop_a: assert property ((i_wheel_function == WHEEL_OFFSET && i_wheel_notch == 5'sd6
      && i_max_offset_sel == MAX_2K)[*8] |-> o_offset_report == K2)
      else $error("end stop offset is not the maximum");
   cover property (o_offset_report_valid);
   cover property (i_window_open && i_cooling);
   cover property (i_wheel_function == WHEEL_OFFSET && o_offset_report == K2);
endmodule
bind rspc_top rspc_chk u_chk (.*);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rspc_pkg::*;
   logic i_clk = 0, i_resetn = 0, i_cooling = 0, i_presence = 0, i_window_open = 0;
   logic [2:0] i_preselect_mode = '0, o_current_mode;
   logic signed [TW-1:0] i_basic_setpoint, i_standby_reduction, i_night_reduction, i_frost_setpoint, i_dead_zone;
   logic signed [TW-1:0] i_standby_increase, i_night_increase, i_heat_protect_setpoint, i_manual_offset;
   logic signed [TW-1:0] o_current_setpoint, o_offset_report, e;
   logic [1:0] i_wheel_function = WHEEL_BASIC, i_max_offset_sel = MAX_3K, i_pair_function = PAIR_NONE;
   logic signed [4:0] i_wheel_notch = '0;
   logic i_manual_offset_valid, i_ext_enable = 1, i_ext_c_is_sensor = 0;
   logic i_ext_input_a = 0, i_ext_input_b = 0, i_ext_input_c = 0, o_offset_report_valid, o_ext_c_analog_sel;
   logic o_obj_a_switch, o_obj_a_aux, o_obj_b_switch, o_obj_shared, o_obj_c_switch;
   int fail_count = 0, num_checks = 0, cycles = 0, k, m, n;
   logic [1:0] wsel[4] = '{MAX_2K, MAX_1K, MAX_3K, MAX_2K};
   logic signed [4:0] wnotch[4] = '{6, 3, -1, 0};
   logic signed [TW-1:0] woff[4] = '{200, 48, -50, 0};
   always #25 i_clk = ~i_clk;
   rspc_top u_dut (.*);
   rspc_bus_node u_node (.i_clk(i_clk), .o_valid(i_manual_offset_valid), .o_value(i_manual_offset));
   task check(input logic signed [TW-1:0] got, input logic signed [TW-1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t ns: got %0d expected %0d", $time, got, exp);
      end
   endtask
   task idle(input int c);
      repeat (c) @(negedge i_clk);
   endtask
   // Shifting every configured figure keeps none of them a constant
   task set_cfg(input int s);
      i_basic_setpoint = 2100 + s;
      i_standby_reduction = 200 + s;
      i_night_reduction = 300 + s;
      i_frost_setpoint = 700 + s;
      i_dead_zone = 200 + s;
      i_standby_increase = 250 + s;
      i_night_increase = 350 + s;
      i_heat_protect_setpoint = 3500 + s;
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         end_of_test;
      end
   end
   initial
   begin
      set_cfg(0);
      idle(8);
      i_resetn = 1;
      u_node.send(100);
      idle(6);
      check(o_offset_report, 100);
      $display("first offset test done");
      for (k = 0; k < 2; k++)
      begin
         set_cfg(k * 10);
         for (m = 0; m < 2; m++)
            for (n = 0; n < 4; n++)
            begin
               i_cooling = m[0];
               i_preselect_mode = n[2:0];
               idle(5);
               e = m ? i_basic_setpoint + 100 + i_dead_zone : i_basic_setpoint + 100;
               if (n == 1) e = m ? e + i_standby_increase : e - i_standby_reduction;
               if (n == 2) e = m ? e + i_night_increase : e - i_night_reduction;
               if (n == 3) e = m ? i_heat_protect_setpoint : i_frost_setpoint;
               check(o_current_setpoint, e);
               check(o_current_mode, n);
            end
      end
      $display("mode table test done");
      i_preselect_mode = MODE_NIGHT;
      i_cooling = 1;
      i_window_open = 1;
      idle(5);
      check(o_current_mode, MODE_PROTECT);
      check(o_current_setpoint, i_heat_protect_setpoint);
      i_cooling = 0;
      idle(5);
      check(o_current_setpoint, i_frost_setpoint);
      i_window_open = 0;
      i_presence = 1;
      i_cooling = 1;
      idle(5);
      check(o_current_mode, MODE_COMFORT);
      check(o_current_setpoint, i_basic_setpoint + 100 + i_dead_zone);
      i_cooling = 0;
      idle(3);
      $display("window and presence test done");
      u_node.send(-500);
      m = 0;
      while (!o_offset_report_valid && m < 10)
      begin
         idle(1);
         m++;
      end
      check(o_offset_report_valid, 1);
      check(o_offset_report, -300);
      u_node.send(200);
      idle(6);
      check(o_offset_report, 200);
      check(o_current_setpoint, i_basic_setpoint + 200);
      i_wheel_function = WHEEL_OFF;
      u_node.send(100);
      idle(6);
      check(o_offset_report, 0);
      i_wheel_function = WHEEL_OFF_OBJ;
      idle(6);
      check(o_offset_report, 200);
      u_node.send(-100);
      idle(6);
      check(o_offset_report, -100);
      $display("manual offset test done");
      i_wheel_function = WHEEL_OFFSET;
      for (k = 0; k < 4; k++)
      begin
         i_max_offset_sel = wsel[k];
         i_wheel_notch = wnotch[k];
         idle(8);
         check(o_offset_report, woff[k]);
      end
      $display("rotary test done");
      i_ext_c_is_sensor = 1;
      idle(5);
      check(o_ext_c_analog_sel, 1);
      i_ext_c_is_sensor = 0;
      i_ext_input_c = 1;
      idle(5);
      check(o_obj_c_switch, 1);
      i_ext_enable = 0;
      idle(5);
      check(o_obj_c_switch, 0);
      i_ext_enable = 1;
      i_ext_input_b = 1;
      idle(5);
      check(o_obj_b_switch, 1);
      i_pair_function = PAIR_BLINDS;
      idle(3);
      check(o_obj_shared, 1);
      check(o_obj_a_switch, 1);
      check(o_obj_b_switch, 0);
      check(o_obj_a_aux, 0);
      i_pair_function = PAIR_DIMMER;
      idle(3);
      check(o_obj_a_aux, 1);
      $display("external input test done");
      end_of_test;
   end
endmodule
`default_nettype wire
